//--- bench/rscl_strap_model.sv
// Strap-driving control device on the shared pins
`timescale 1ns/1ns
`default_nettype none
module rscl_strap_model (
    input wire logic resetStatusOut,
    input wire logic [rscl_pkg::STRAP_W-1:0] strapVal,
    output logic [rscl_pkg::STRAP_W-1:0] strapOut,
    output logic strapOe
);
    import rscl_pkg::*;
    // Drive only while status is low, so no contention afterwards
    assign strapOe = !resetStatusOut;
    // Strap values come from the bench table of legal codes only
    assign strapOut = strapVal;
endmodule
`default_nettype wire

//--- bench/rscl_top_checker.sv
// Port-level assertions for the reset strap latch
`timescale 1ns/1ns
`default_nettype none
module rscl_top_checker (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic extMemAddrPinsOe,
    input wire logic extMemBankPinsOe,
    input wire logic [rscl_pkg::ADDR_W-1:0] extMemAddrPinsO,
    input wire logic [rscl_pkg::ADDR_W-1:0] memPortAddr,
    input wire logic resetStatusOut,
    input wire logic [3:0] bootSelectField,
    input wire logic extMemClockSourceSel,
    input wire logic [rscl_pkg::EN_W-1:0] periphEnable
);
    import rscl_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    // Boot code to enable mask; reserved codes enable nothing
    function automatic logic [EN_W-1:0] bootEn(input logic [3:0] c);
        case (c)
            BOOT_HPI: return 4'h1;
            BOOT_ROM: return 4'h2;
            BOOT_I2CM, BOOT_I2CS: return 4'h4;
            BOOT_PCI: return 4'h8;
            default: return EN_NONE;
        endcase
    endfunction

    chk_oe_follows_status: assert property (
        extMemAddrPinsOe == resetStatusOut && extMemBankPinsOe == resetStatusOut)
        else $error("pin enable differs from status");
    chk_boot_held: assert property (
        resetStatusOut && $past(resetStatusOut) |-> $stable(bootSelectField))
        else $error("boot field moved after latch");
    chk_clksel_held: assert property (
        resetStatusOut && $past(resetStatusOut)
        |-> $stable(extMemClockSourceSel))
        else $error("clock select moved after latch");
    chk_status_stays: assert property (
        resetStatusOut |=> resetStatusOut)
        else $error("status fell without reset");
    chk_pins_driven: assert property (
        extMemAddrPinsOe && $past(extMemAddrPinsOe)
        |-> extMemAddrPinsO == $past(memPortAddr))
        else $error("address pins not driven from port");
    chk_boot_enable: assert property (
        $rose(resetStatusOut) |-> periphEnable == bootEn(bootSelectField))
        else $error("wrong boot peripheral enabled");
    chk_none_early: assert property (
        !resetStatusOut |-> periphEnable == EN_NONE)
        else $error("peripheral enabled before latch");
    chk_latch_bound: assert property (
        !resetStatusOut |-> ##[1:8] resetStatusOut)
        else $error("latch did not close in time");

    cov_pci: cover property ($rose(resetStatusOut) && periphEnable[EN_PCI]);
    cov_i2c: cover property ($rose(resetStatusOut) && periphEnable[EN_I2C]);
    cov_clk: cover property ($rose(resetStatusOut) && extMemClockSourceSel);
endmodule

bind rscl_top rscl_top_checker rscl_top_checker_i (.clk_sys, .nrst,
    .extMemAddrPinsOe, .extMemBankPinsOe, .extMemAddrPinsO, .memPortAddr,
    .resetStatusOut, .bootSelectField, .extMemClockSourceSel,
    .periphEnable);
`default_nettype wire

//--- bench/rscl_top_tb.sv
// Self-checking bench for the reset strap latch
`timescale 1ns/1ns
`default_nettype none
module rscl_top_tb;
    import rscl_pkg::*;
    logic clk_sys = 0, nrst = 0, extMemAddrPinsOe, extMemBankPinsOe;
    logic [ADDR_W-1:0] extMemAddrPinsO, extMemAddrPinsI, memPortAddr = 0;
    logic [BANK_W-1:0] extMemBankPinsO, extMemBankPinsI, memPortBank = 0;
    logic hostSelPin, resetStatusOut, extMemClockSourceSel;
    logic dividedSystemClockFour, strapOe;
    logic [3:0] bootSelectField, s_axi_wstrb = 4'hF;
    logic [EN_W-1:0] periphEnable;
    logic [AXI_AW-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [STRAP_W-1:0] strapVal = 0, strapOut, sv;
    logic [31:0] rd;
    int n_mismatch = 0, n_compared = 0, cyc = 0, p;
    // Legal boot codes and the peripheral each one enables
    logic [3:0] codes [6] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h7};
    logic [3:0] ens [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h4, 4'h8};

    always #2 clk_sys = ~clk_sys;
    // Pin level: device, else control device, else pulldown
    assign extMemAddrPinsI = extMemAddrPinsOe ? extMemAddrPinsO :
        strapOe ? strapOut[19:0] : '0;
    assign extMemBankPinsI = extMemBankPinsOe ? extMemBankPinsO :
        strapOe ? strapOut[21:20] : '0;
    assign hostSelPin = strapOe ? strapOut[22] : 1'b0;

    rscl_top rscl_top_i (.clk_sys, .nrst, .extMemAddrPinsI, .extMemAddrPinsO,
        .extMemAddrPinsOe, .extMemBankPinsI, .extMemBankPinsO,
        .extMemBankPinsOe, .hostSelPin, .memPortAddr, .memPortBank,
        .resetStatusOut, .bootSelectField, .extMemClockSourceSel,
        .dividedSystemClockFour, .periphEnable, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    rscl_strap_model rscl_strap_model_i (.resetStatusOut, .strapVal,
        .strapOut, .strapOe);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic close_out;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Write: address and data offered together, each released when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic aw, w;
        aw = 1;
        w = 1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (aw || w) begin
            @(posedge clk_sys);
            if (aw && s_axi_awready) begin
                s_axi_awvalid <= 0;
                aw = 0;
            end
            if (w && s_axi_wready) begin
                s_axi_wvalid <= 0;
                w = 0;
            end
        end
        do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 0;
        rsp = s_axi_bresp;
    endtask

    // Read: hold the request until taken, then wait for the answer
    task automatic axr(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 0;
        while (s_axi_rvalid !== 1'b1) @(posedge clk_sys);
        s_axi_rready <= 0;
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        @(posedge clk_sys);
    endtask

    // Period of clock four, counted in core cycles between two rises
    task automatic period;
        int r0;
        logic pv;
        r0 = -1;
        p = 0;
        pv = dividedSystemClockFour;
        for (int k = 0; k < 64 && p == 0; k++) begin
            @(posedge clk_sys);
            if (!pv && dividedSystemClockFour) begin
                if (r0 < 0) r0 = k;
                else p = k - r0;
            end
            pv = dividedSystemClockFour;
        end
    endtask

    // Hang guard: far above the length of the sequence
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end

    initial begin
        for (int i = 0; i < 6; i++) begin
            sv = {i[0], i[1:0], codes[i], i[0], 15'h2A5C};
            strapVal <= sv;
            nrst <= 0;
            memPortAddr <= 20'h0;
            repeat (16) @(posedge clk_sys);
            nrst <= 1;
            // Enable write while still sampling must be dropped
            axw(REG_PEN, 32'hF);
            chk(rsp, RESP_OKAY);
            for (int k = 0; k < 20 && resetStatusOut !== 1'b1; k++)
                @(posedge clk_sys);
            chk(resetStatusOut, 1);
            chk(bootSelectField, codes[i]);
            chk(extMemClockSourceSel, i[0]);
            chk(periphEnable, ens[i]);
            // Pins now belong to the memory port, straps are ignored
            memPortAddr <= 20'hF0F0F;
            memPortBank <= ~sv[21:20];
            repeat (3) @(posedge clk_sys);
            chk(extMemAddrPinsI, 20'hF0F0F);
            chk(extMemBankPinsI, memPortBank);
            axr(REG_STATUS);
            chk(rd, {9'h0, sv});
            axr(REG_BOOT);
            chk(rd, {27'h0, i[0], codes[i]});
            axr(REG_PEN);
            chk(rd, {28'h0, ens[i]});
        end
        axr(REG_DIV);
        chk(rd, 32'h8);
        period();
        chk(p, 8);
        axw(REG_DIV, 32'h4);
        chk(rsp, RESP_OKAY);
        period();
        chk(p, 4);
        axw(REG_PEN, 32'hB);
        axr(REG_PEN);
        chk(rd, 32'hB);
        chk(periphEnable, 4'hB);
        axr(8'h10);
        chk(rsp, RESP_SLVERR);
        close_out();
    end
endmodule
`default_nettype wire

//--- pkg/rscl_clk_if.sv
// Link between the latch and the divided clock four generator
`timescale 1ns/1ns
`default_nettype none
interface rscl_clk_if;
    import rscl_pkg::*;
    logic [DIV_W-1:0] divisor; // Software divide ratio
    logic clkFour; // Divided clock output
    modport ctl (output divisor, input clkFour);
    modport div (input divisor, output clkFour);
endinterface
`default_nettype wire

//--- pkg/rscl_pkg.sv
// Constants and state types of the reset strap configuration latch
package rscl_pkg;
    // Strap vector layout: {host select, bank pins, address pins}
    localparam int ADDR_W = 20;
    localparam int BANK_W = 2;
    localparam int STRAP_W = 23;
    localparam int HSEL_BIT = 22;
    localparam int RSV_BIT = 23;
    localparam int BOOT_HI = 19;
    localparam int BOOT_LO = 16;
    localparam int CLKSEL_BIT = 15;
    localparam int BOOTREG_CLK = 4;
    localparam int BOOTREG_RSV = 5;
    // Boot select codes
    localparam logic [3:0] BOOT_NONE = 4'h0;
    localparam logic [3:0] BOOT_HPI = 4'h1;
    localparam logic [3:0] BOOT_ROM = 4'h4;
    localparam logic [3:0] BOOT_I2CM = 4'h5;
    localparam logic [3:0] BOOT_I2CS = 4'h6;
    localparam logic [3:0] BOOT_PCI = 4'h7;
    // Peripheral enable bit positions
    localparam int EN_W = 4;
    localparam int EN_HPI = 0;
    localparam int EN_EMIF = 1;
    localparam int EN_I2C = 2;
    localparam int EN_PCI = 3;
    localparam logic [EN_W-1:0] EN_NONE = 4'h0;
    // Register map, byte addresses
    localparam int AXI_AW = 8;
    localparam logic [AXI_AW-1:0] REG_STATUS = 8'h00;
    localparam logic [AXI_AW-1:0] REG_BOOT = 8'h04;
    localparam logic [AXI_AW-1:0] REG_PEN = 8'h08;
    localparam logic [AXI_AW-1:0] REG_DIV = 8'h0C;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Divided system clock four: CPU rate over eight after reset
    localparam int DIV_W = 8;
    localparam logic [DIV_W-1:0] DIV_DEFAULT = 8'h08;
    localparam logic [DIV_W-1:0] DIV_MIN = 8'h02;
    // Cycles the pins settle after release before the latch closes
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] SETTLE_CYC = 4'h4;

    typedef enum logic [0:0] {PH_SAMPLE, PH_RUN} rscl_phase_t;

    // Divider state
    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic clkOut;
    } rscl_div_st_t;

    // Whole state of the latch and its register slave
    typedef struct packed {
        logic [STRAP_W-1:0] sync1;
        logic [STRAP_W-1:0] sync2;
        rscl_phase_t phase;
        logic [CNT_W-1:0] cnt;
        logic [STRAP_W-1:0] cfg;
        logic rstStat;
        logic [EN_W-1:0] periphEn;
        logic [DIV_W-1:0] divisor;
        logic [ADDR_W-1:0] addrDrv;
        logic [BANK_W-1:0] bankDrv;
        logic awHave;
        logic [AXI_AW-1:0] awAddr;
        logic wHave;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
    } rscl_st_t;
endpackage

//--- verilog/rscl_clkdiv.sv
// Generator of divided system clock four from the core clock
`timescale 1ns/1ns
`default_nettype none
module rscl_clkdiv (
    input wire logic clk_sys,
    input wire logic nrst,
    rscl_clk_if.div clkIf
);
    import rscl_pkg::*;

    rscl_div_st_t q; // Registered state
    rscl_div_st_t d; // Next state
    logic [DIV_W-1:0] effDiv; // Ratio clamped to something divisible

    // Count one period and hold the output high for its first half
    always_comb begin
        d = q;
        effDiv = (clkIf.divisor < DIV_MIN) ? DIV_MIN : clkIf.divisor;
        // Wrap on the last cycle of the period
        if (q.cnt >= effDiv - DIV_W'(1)) begin
            d.cnt = '0;
        end else begin
            d.cnt = q.cnt + DIV_W'(1);
        end
        // Odd ratios give a short high half; fine for a clock select
        d.clkOut = (d.cnt < (effDiv >> 1));
    end

    // State register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign clkIf.clkFour = q.clkOut;
endmodule
`default_nettype wire

//--- verilog/rscl_top.sv
// Reset strap latch: captures pin straps, decodes boot and clock setup
`timescale 1ns/1ns
`default_nettype none
module rscl_top (
    input wire logic clk_sys,
    input wire logic nrst,
    // Shared strap pins: address, bank, host-bus select
    input wire logic [rscl_pkg::ADDR_W-1:0] extMemAddrPinsI,
    output logic [rscl_pkg::ADDR_W-1:0] extMemAddrPinsO,
    output logic extMemAddrPinsOe,
    input wire logic [rscl_pkg::BANK_W-1:0] extMemBankPinsI,
    output logic [rscl_pkg::BANK_W-1:0] extMemBankPinsO,
    output logic extMemBankPinsOe,
    input wire logic hostSelPin,
    // Values the memory port puts on the pins after reset
    input wire logic [rscl_pkg::ADDR_W-1:0] memPortAddr,
    input wire logic [rscl_pkg::BANK_W-1:0] memPortBank,
    // Reset status pin, high once the device is out of reset
    output logic resetStatusOut,
    // Decoded configuration
    output logic [3:0] bootSelectField,
    output logic extMemClockSourceSel,
    output logic dividedSystemClockFour,
    output logic [rscl_pkg::EN_W-1:0] periphEnable,
    // AXI4-Lite slave
    input wire logic [rscl_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [rscl_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import rscl_pkg::*;

    rscl_st_t q; // Registered state
    rscl_st_t d; // Next state
    logic [EN_W-1:0] bootEn; // Peripheral named by the boot code
    logic rsvSeen; // Latched boot code is one of the reserved ones
    logic [3:0] bootCode; // Boot field of the settled strap sample
    logic [31:0] readWord; // Read data mux
    logic [1:0] readResp; // Read answer for the decoded address

    rscl_clk_if clkIf (); // Divider link

    // Divided clock four generator
    rscl_clkdiv uDiv (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .clkIf(clkIf)
    );

    assign clkIf.divisor = q.divisor;

    // Boot code decode; reserved codes enable nothing
    always_comb begin
        bootCode = q.sync2[BOOT_HI:BOOT_LO];
        bootEn = EN_NONE;
        case (bootCode)
            BOOT_NONE: begin
                bootEn = EN_NONE;
            end
            BOOT_HPI: begin
                bootEn[EN_HPI] = 1'b1;
            end
            BOOT_ROM: begin
                bootEn[EN_EMIF] = 1'b1;
            end
            BOOT_I2CM, BOOT_I2CS: begin
                bootEn[EN_I2C] = 1'b1;
            end
            BOOT_PCI: begin
                bootEn[EN_PCI] = 1'b1;
            end
            default: begin
                // Reserved code: nothing enabled
                bootEn = EN_NONE;
            end
        endcase
    end

    // Reserved code check on the latched field, so status never tracks pins
    always_comb begin
        case (q.cfg[BOOT_HI:BOOT_LO])
            BOOT_NONE, BOOT_HPI, BOOT_ROM,
            BOOT_I2CM, BOOT_I2CS, BOOT_PCI: begin
                rsvSeen = 1'b0;
            end
            default: begin
                rsvSeen = 1'b1;
            end
        endcase
    end

    // Read mux; only the four words are mapped
    always_comb begin
        readWord = '0;
        readResp = RESP_OKAY;
        case (s_axi_araddr)
            REG_STATUS: begin
                readWord[STRAP_W-1:0] = q.cfg;
                readWord[RSV_BIT] = rsvSeen;
            end
            REG_BOOT: begin
                readWord[3:0] = q.cfg[BOOT_HI:BOOT_LO];
                readWord[BOOTREG_CLK] = q.cfg[CLKSEL_BIT];
            end
            REG_PEN: begin
                readWord[EN_W-1:0] = q.periphEn;
            end
            REG_DIV: begin
                readWord[DIV_W-1:0] = q.divisor;
            end
            default: begin
                // Unmapped word: zero data, slave error
                readResp = RESP_SLVERR;
            end
        endcase
    end

    // Next-state logic: strap sampling, capture, pin drive and bus slave
    always_comb begin
        d = q;
        // Two-stage synchroniser on the strap pins
        d.sync1 = {hostSelPin, extMemBankPinsI, extMemAddrPinsI};
        d.sync2 = q.sync1;
        // Pin drive values, registered so the pins come from flops
        d.addrDrv = memPortAddr;
        d.bankDrv = memPortBank;

        case (q.phase)
            PH_SAMPLE: begin
                // Pins still undriven by us; let the sample settle
                if (q.cnt == SETTLE_CYC) begin
                    d.cfg = q.sync2;
                    d.periphEn = bootEn;
                    d.rstStat = 1'b1;
                    d.phase = PH_RUN;
                end else begin
                    d.cnt = q.cnt + CNT_W'(1);
                end
            end
            PH_RUN: begin
                // Configuration frozen until nrst falls again
                d.cfg = q.cfg;
            end
            default: begin
                d.phase = PH_SAMPLE;
            end
        endcase

        // Write address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready) begin
            d.awHave = 1'b1;
            d.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.wHave = 1'b1;
            d.wData = s_axi_wdata;
            d.wStrb = s_axi_wstrb;
        end
        // Perform the write once both halves are held
        if (q.awHave && q.wHave && !q.bValid) begin
            d.awHave = 1'b0;
            d.wHave = 1'b0;
            d.bValid = 1'b1;
            d.bResp = RESP_OKAY;
            case (q.awAddr)
                REG_PEN: begin
                    // Software enables; ignored while still sampling
                    if (q.wStrb[0] && q.phase == PH_RUN) begin
                        d.periphEn = q.wData[EN_W-1:0];
                    end
                end
                REG_DIV: begin
                    if (q.wStrb[0]) begin
                        d.divisor = q.wData[DIV_W-1:0];
                    end
                end
                REG_STATUS, REG_BOOT: begin
                    // Read-only words: write dropped, answered OKAY
                    d.bResp = RESP_OKAY;
                end
                default: begin
                    d.bResp = RESP_SLVERR;
                end
            endcase
        end
        if (q.bValid && s_axi_bready) begin
            d.bValid = 1'b0;
        end

        // Read: answer one cycle after the address is taken
        if (s_axi_arvalid && s_axi_arready) begin
            d.rValid = 1'b1;
            d.rData = readWord;
            d.rResp = readResp;
        end else if (q.rValid && s_axi_rready) begin
            d.rValid = 1'b0;
        end
    end

    // State register; every field resets to a constant
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
            q.phase <= PH_SAMPLE;
            q.periphEn <= EN_NONE;
            q.divisor <= DIV_DEFAULT;
        end else begin
            q <= d;
        end
    end

    // Pins are driven only once the latch has closed
    assign extMemAddrPinsO = q.addrDrv;
    assign extMemAddrPinsOe = q.rstStat;
    assign extMemBankPinsO = q.bankDrv;
    assign extMemBankPinsOe = q.rstStat;
    // External strap drivers must be off once this goes high
    assign resetStatusOut = q.rstStat;

    // Decoded configuration outputs
    assign bootSelectField = q.cfg[BOOT_HI:BOOT_LO];
    assign extMemClockSourceSel = q.cfg[CLKSEL_BIT];
    assign dividedSystemClockFour = clkIf.clkFour;
    assign periphEnable = q.periphEn;

    // Bus handshakes; one write and one read outstanding at most
    assign s_axi_awready = !q.awHave && !q.bValid;
    assign s_axi_wready = !q.wHave && !q.bValid;
    assign s_axi_bvalid = q.bValid;
    assign s_axi_bresp = q.bResp;
    assign s_axi_arready = !q.rValid;
    assign s_axi_rvalid = q.rValid;
    assign s_axi_rdata = q.rData;
    assign s_axi_rresp = q.rResp;
endmodule
`default_nettype wire
